// [drive_cmd_defines.svh]
`ifndef DRIVE_CMD_DEFINES_SVH
`define DRIVE_CMD_DEFINES_SVH
// Functional notes
// [R1] Control-mode key arms a request; confirm enters full keypad, cancel drops it.
// [R2] Any changeover into or out of full keypad stops motor, forces forward.
// [R3] Full keypad alternates warning with normal status on the display.
// [R4] Full keypad ignores standard setpoints, refuses setpoint or network switches.
// [R5] Enable, quick stop, DC brake, jog, invert, faults keep acting in full keypad.
// [R6] Second control-mode press, confirmed, leaves full keypad to previous source.
// [R7] Drive enable needed for start; false disables output stage at once.
// [R8] Run is a forward level command when no start commands or sources mapped.
// [R9] Otherwise run is start enable; false stops the motor.
// [R10] Quick stop brings motor to standstill fastest, overriding run requests.
// [R11] Edge starts start on rising edge with run true; run false stops.
// [R12] Edge starts and level runs ignored under keypad or network control.
// [R13] Level run commands hold rotation while asserted and run is true.
// [R14] Jog runs at jog setpoint, over run, other starts and keypad stop.
// [R15] Quick stop still aborts an active jog.
// [R16] Jog accepted under any control source.
// [R17] Invert rotation negates setpoint, except under network control.
// [R18] Flexible I/O with neither enable nor run on an input raises error.
// [R19] Keypad or network control accepts enable and run as constant true.
// [R20] Edge starts mapped together with level runs raise the error.
// [R21] Full keypad holds run true internally.
// [R22] Start already true at start enable waits for next rising edge.
// [R23] Evaluate once per cycle: disable, quick stop, jog, then source commands.

// Error code for wrong trigger assignment
`define DRV_ERR_WRONG_ASSIGN 16'h6280
// Display toggle period in cycles (40 MHz, 0.5 s)
`define DRV_BLINK_NS         500000000
`define DRV_CLK_NS           25
`define DRV_BLINK_CYC        (`DRV_BLINK_NS / `DRV_CLK_NS)
`define DRV_BLINK_W          25
`endif

// [drive_cmd_pkg.sv]
package drive_cmd_pkg;
  // Trigger mapping status of enable, run, edge starts and level runs
  typedef struct packed {
    logic drive_enable_on_input;
    logic run_on_input;
    logic edge_starts_mapped;
    logic level_runs_mapped;
  } map_type;

  // Function trigger levels
  typedef struct packed {
    logic drive_enable_fn;
    logic run_fn;
    logic quick_stop_fn;
    logic dc_brake_fn;
    logic start_fwd_edge_fn;
    logic start_rev_edge_fn;
    logic run_fwd_level_fn;
    logic run_rev_level_fn;
    logic jog_fwd_fn;
    logic jog_rev_fn;
    logic invert_rotation_fn;
    logic ext_fault_one_fn;
    logic ext_fault_two_fn;
  } fn_type;

  // Keypad key pulses
  typedef struct packed {
    logic ctrl_key;
    logic confirm_key;
    logic cancel_key;
    logic start_key;
    logic stop_key;
    logic rev_key;
  } keys_type;

  // Network command levels
  typedef struct packed {
    logic run;
    logic rev;
  } net_cmd_type;

  // Command to the motor controller
  typedef struct packed {
    logic output_enable;
    logic run;
    logic reverse;
    logic jog;
    logic quick_stop;
    logic dc_brake;
    logic ext_fault_one;
    logic ext_fault_two;
    logic setpoint_negate;
    logic use_keypad_setpoint;
    logic changeover_stop;
  } motor_cmd_type;

  typedef enum logic [1:0] {SRC_FLEX, SRC_KEYPAD, SRC_NETWORK} src_type;
  typedef enum {KF_IDLE, KF_ASK_ON, KF_ACTIVE, KF_ASK_OFF} kf_state_type;
endpackage : drive_cmd_pkg

// [drive_command_arbiter.sv]
`timescale 1ns/100ps
`include "drive_cmd_defines.svh"
module drive_command_arbiter (
  // Clock and reset
  input  wire logic                        clk_sys_i,
  input  wire logic                        sys_rst_i,
  // Configuration
  input  wire drive_cmd_pkg::src_type      sel_src_i,
  input  wire drive_cmd_pkg::map_type      map_i,
  input  wire logic                        setpoint_switch_req_i,
  // Commands
  input  wire drive_cmd_pkg::fn_type       fn_i,
  input  wire drive_cmd_pkg::keys_type     keys_i,
  input  wire drive_cmd_pkg::net_cmd_type  net_i,
  // Outputs
  output drive_cmd_pkg::motor_cmd_type     cmd_o,
  output drive_cmd_pkg::src_type           active_src_o,
  output logic                             full_keypad_o,
  output logic                             ask_on_o,
  output logic                             ask_off_o,
  output logic                             show_warning_o,
  output logic                             setpoint_switch_ok_o,
  output logic                             wrong_assign_o,
  output logic [15:0]                      error_code_o
);
  import drive_cmd_pkg::*;

  // ****************************************
  // Full keypad mode
  // ****************************************
  kf_state_type kf_ff, nxt_kf;
  logic         change_pulse;
  always_comb begin
    nxt_kf       = kf_ff;
    change_pulse = 1'b0;
    case (kf_ff)
      // [R1] Arm then confirm
      KF_IDLE:    if (keys_i.ctrl_key) nxt_kf = KF_ASK_ON;
      KF_ASK_ON:  if (keys_i.confirm_key) begin
                    nxt_kf       = KF_ACTIVE;
                    change_pulse = 1'b1;
                  end else if (keys_i.cancel_key) nxt_kf = KF_IDLE;
      // [R6] Second press exits
      KF_ACTIVE:  if (keys_i.ctrl_key) nxt_kf = KF_ASK_OFF;
      KF_ASK_OFF: if (keys_i.confirm_key) begin
                    nxt_kf       = KF_IDLE;
                    change_pulse = 1'b1;
                  end else if (keys_i.cancel_key) nxt_kf = KF_ACTIVE;
      default:    nxt_kf = KF_IDLE;
    endcase
  end
  wire full_kp = (kf_ff == KF_ACTIVE) || (kf_ff == KF_ASK_OFF);

  // Previous source kept outside; full keypad overlays it
  // [R4] Network switch refused in full keypad
  wire src_type eff_src = full_kp ? SRC_KEYPAD : sel_src_i;
  wire kp_ctl   = (eff_src == SRC_KEYPAD);
  wire net_ctl  = (eff_src == SRC_NETWORK);

  // ****************************************
  // Command evaluation
  // ****************************************
  // [R21] Run forced true
  wire run_eff   = full_kp | fn_i.run_fn;
  // [R8] Level mode selection
  wire run_level = !map_i.edge_starts_mapped && !map_i.level_runs_mapped
                   && !kp_ctl && !net_ctl;
  logic run_ff, rev_ff, sfwd_q_ff, srev_q_ff, kp_run_ff, kp_rev_ff;
  logic [`DRV_BLINK_W-1:0] blink_cnt_ff;
  logic blink_ff;

  // [R11] Rising edges; [R12] ignored under keypad or network
  wire ext_ok   = !kp_ctl && !net_ctl;
  wire sfwd_rise = fn_i.start_fwd_edge_fn && !sfwd_q_ff && ext_ok;
  wire srev_rise = fn_i.start_rev_edge_fn && !srev_q_ff && ext_ok;
  wire jog_req  = fn_i.jog_fwd_fn | fn_i.jog_rev_fn;

  logic nxt_run, nxt_rev;
  always_comb begin
    nxt_run = run_ff;
    nxt_rev = rev_ff;
    // [R7] [R23] Disable first
    if (!fn_i.drive_enable_fn) nxt_run = 1'b0;
    // [R10] Quick stop overrides
    else if (fn_i.quick_stop_fn) nxt_run = 1'b0;
    // [R2] Changeover stops, forward
    else if (change_pulse) begin
      nxt_run = 1'b0;
      nxt_rev = 1'b0;
    end
    // [R9] Start enable false stops
    else if (!run_eff) nxt_run = 1'b0;
    else if (run_level) begin
      nxt_run = 1'b1;
      nxt_rev = 1'b0;
    end else if (net_ctl) begin
      nxt_run = net_i.run;
      nxt_rev = net_i.rev;
    end else if (kp_ctl) begin
      nxt_run = kp_run_ff;
      nxt_rev = kp_rev_ff;
    end else if (map_i.level_runs_mapped) begin
      // [R13] Level run holds
      nxt_run = fn_i.run_fwd_level_fn ^ fn_i.run_rev_level_fn;
      nxt_rev = fn_i.run_rev_level_fn;
    end else if (sfwd_rise) begin
      nxt_run = 1'b1;
      nxt_rev = 1'b0;
    end else if (srev_rise) begin
      nxt_run = 1'b1;
      nxt_rev = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      kf_ff        <= KF_IDLE;
      run_ff       <= 1'b0;
      rev_ff       <= 1'b0;
      sfwd_q_ff    <= 1'b1;
      srev_q_ff    <= 1'b1;
      kp_run_ff    <= 1'b0;
      kp_rev_ff    <= 1'b0;
      blink_cnt_ff <= '0;
      blink_ff     <= 1'b0;
    end else begin
      kf_ff     <= nxt_kf;
      run_ff    <= nxt_run;
      rev_ff    <= nxt_rev;
      // [R22] Edge memory spans disabled time
      sfwd_q_ff <= fn_i.start_fwd_edge_fn;
      srev_q_ff <= fn_i.start_rev_edge_fn;
      if (change_pulse || !kp_ctl || keys_i.stop_key) begin
        kp_run_ff <= 1'b0;
        kp_rev_ff <= 1'b0;
      end else begin
        if (keys_i.start_key) kp_run_ff <= 1'b1;
        if (keys_i.rev_key)   kp_rev_ff <= !kp_rev_ff;
      end
      // [R3] Display alternation
      if (!full_kp || blink_cnt_ff == `DRV_BLINK_W'(`DRV_BLINK_CYC - 1)) begin
        blink_cnt_ff <= '0;
        blink_ff     <= full_kp ? !blink_ff : 1'b0;
      end else blink_cnt_ff <= blink_cnt_ff + 1'b1;
    end
  end

  // ****************************************
  // Output register
  // ****************************************
  // [R18] [R19] [R20] Assignment check
  wire bad_assign = (sel_src_i == SRC_FLEX && !full_kp &&
                     !map_i.drive_enable_on_input && !map_i.run_on_input)
                    || (map_i.edge_starts_mapped && map_i.level_runs_mapped);
  // [R14] [R15] [R16] Jog overrides, quick stop aborts
  wire jog_go = fn_i.drive_enable_fn && !fn_i.quick_stop_fn && jog_req;
  motor_cmd_type nxt_cmd;
  always_comb begin
    nxt_cmd                 = '0;
    nxt_cmd.output_enable   = fn_i.drive_enable_fn;
    nxt_cmd.quick_stop      = fn_i.quick_stop_fn;
    // [R5] Functions still active
    nxt_cmd.dc_brake        = fn_i.dc_brake_fn;
    nxt_cmd.ext_fault_one   = fn_i.ext_fault_one_fn;
    nxt_cmd.ext_fault_two   = fn_i.ext_fault_two_fn;
    nxt_cmd.jog             = jog_go;
    nxt_cmd.run             = jog_go | nxt_run;
    nxt_cmd.reverse         = jog_go ? !fn_i.jog_fwd_fn : nxt_rev;
    // [R17] Invert except network
    nxt_cmd.setpoint_negate = fn_i.invert_rotation_fn && !net_ctl;
    nxt_cmd.use_keypad_setpoint = full_kp;
    nxt_cmd.changeover_stop = change_pulse;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cmd_o                <= '0;
      active_src_o         <= SRC_FLEX;
      full_keypad_o        <= 1'b0;
      ask_on_o             <= 1'b0;
      ask_off_o            <= 1'b0;
      show_warning_o       <= 1'b0;
      setpoint_switch_ok_o <= 1'b0;
      wrong_assign_o       <= 1'b0;
      error_code_o         <= 16'h0000;
    end else begin
      cmd_o                <= nxt_cmd;
      active_src_o         <= eff_src;
      full_keypad_o        <= full_kp;
      ask_on_o             <= (kf_ff == KF_ASK_ON);
      ask_off_o            <= (kf_ff == KF_ASK_OFF);
      show_warning_o       <= full_kp && blink_ff;
      setpoint_switch_ok_o <= setpoint_switch_req_i && !full_kp;
      wrong_assign_o       <= bad_assign;
      error_code_o         <= bad_assign ? `DRV_ERR_WRONG_ASSIGN : 16'h0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_disable;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !fn_i.drive_enable_fn |=> !cmd_o.output_enable && !cmd_o.run;
  endproperty
  a_disable: assert property (p_disable) else $error("enable ignored"); // [R7]

  property p_qstop;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    fn_i.quick_stop_fn |=> !cmd_o.run && !cmd_o.jog;
  endproperty
  a_qstop: assert property (p_qstop) else $error("quick stop lost"); // [R15]

  property p_jog;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (jog_req && fn_i.drive_enable_fn && !fn_i.quick_stop_fn)
      |=> cmd_o.run && cmd_o.jog;
  endproperty
  a_jog: assert property (p_jog) else $error("jog not taken"); // [R14]

  sequence s_ask;
    kf_ff == KF_ASK_ON && keys_i.confirm_key;
  endsequence
  property p_enter;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    s_ask |=> full_kp ##1 (full_keypad_o && !cmd_o.run && !cmd_o.reverse);
  endproperty
  a_enter: assert property (p_enter) else $error("entry failed"); // [R2]

  property p_cancel;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (kf_ff == KF_ASK_ON && !keys_i.confirm_key && keys_i.cancel_key)
      |=> kf_ff == KF_IDLE;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel failed"); // [R1]

  property p_invert;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    net_ctl |=> !cmd_o.setpoint_negate;
  endproperty
  a_invert: assert property (p_invert) else $error("invert in net"); // [R17]

  property p_err;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (map_i.edge_starts_mapped && map_i.level_runs_mapped)
      |=> wrong_assign_o && error_code_o == 16'h6280;
  endproperty
  a_err: assert property (p_err) else $error("no error raised"); // [R20]

  property p_net_ignore;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    full_kp |=> active_src_o == SRC_KEYPAD && !setpoint_switch_ok_o;
  endproperty
  a_net_ignore: assert property (p_net_ignore) else $error("src switched"); // [R4]

  property p_warn;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !full_kp |=> !show_warning_o;
  endproperty
  a_warn: assert property (p_warn) else $error("warning outside"); // [R3]

  property p_pass;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    1'b1 |=> cmd_o.dc_brake == $past(fn_i.dc_brake_fn)
             && cmd_o.ext_fault_one == $past(fn_i.ext_fault_one_fn)
             && cmd_o.ext_fault_two == $past(fn_i.ext_fault_two_fn);
  endproperty
  a_pass: assert property (p_pass) else $error("function dropped"); // [R5]

  sequence s_ask_off;
    kf_ff == KF_ASK_OFF && keys_i.confirm_key;
  endsequence
  property p_exit;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    s_ask_off |=> (kf_ff == KF_IDLE) ##1 !full_keypad_o;
  endproperty
  a_exit: assert property (p_exit) else $error("exit failed"); // [R6]

  property p_level;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (run_level && run_eff && fn_i.drive_enable_fn && !fn_i.quick_stop_fn
     && !change_pulse) |=> cmd_o.run;
  endproperty
  a_level: assert property (p_level) else $error("level run lost"); // [R8]

  property p_runlow;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (!run_eff && !jog_req) |=> !cmd_o.run;
  endproperty
  a_runlow: assert property (p_runlow) else $error("run low ran"); // [R9]

  property p_kp_ignore;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (kp_ctl && !jog_req && !kp_run_ff) |=> !cmd_o.run;
  endproperty
  a_kp_ignore: assert property (p_kp_ignore) else $error("ext start"); // [R12]

  property p_jog_net;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (net_ctl && jog_go) |=> cmd_o.jog && cmd_o.run;
  endproperty
  a_jog_net: assert property (p_jog_net) else $error("jog refused"); // [R16]

  property p_wrong_flex;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (sel_src_i == SRC_FLEX && !full_kp && !map_i.drive_enable_on_input
     && !map_i.run_on_input) |=> wrong_assign_o;
  endproperty
  a_wrong_flex: assert property (p_wrong_flex) else $error("no flex err"); // [R18]

  property p_forced;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (full_kp && kp_run_ff && fn_i.drive_enable_fn && !fn_i.quick_stop_fn
     && !change_pulse) |=> cmd_o.run;
  endproperty
  a_forced: assert property (p_forced) else $error("run not held"); // [R21]

  property p_rearm;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (fn_i.start_fwd_edge_fn && sfwd_q_ff && !fn_i.start_rev_edge_fn
     && !run_ff && map_i.edge_starts_mapped && !map_i.level_runs_mapped
     && ext_ok && !jog_req) |=> !cmd_o.run;
  endproperty
  a_rearm: assert property (p_rearm) else $error("held start ran"); // [R22]
endmodule : drive_command_arbiter

// [key_pad_model.sv]
`timescale 1ns/100ps
module key_pad_model (
  // Clock
  input  wire logic                    clk_sys_i,
  // Key requests from the bench
  input  wire drive_cmd_pkg::keys_type key_req_i,
  // Key pulses to the block
  output drive_cmd_pkg::keys_type      keys_o
);
  import drive_cmd_pkg::*;
  // ****************
  // Key scan
  // ****************
  // Registered so a key never reaches the block mid-cycle
  always_ff @(posedge clk_sys_i) begin
    keys_o <= key_req_i;
  end
endmodule : key_pad_model

// [tb_drive_command_arbiter.sv]
`timescale 1ns/100ps
module tb_drive_command_arbiter;
  import drive_cmd_pkg::*;
  // ****************
  // Stimulus and checks
  // ****************
  logic          clk_sys_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  src_type       sel_src_i = SRC_FLEX;
  map_type       map_i     = '0;
  logic          sp_req    = 1'b0;
  fn_type        fn_i      = '0;
  keys_type      key_req   = '0;
  keys_type      keys_i;
  net_cmd_type   net_i     = '0;
  motor_cmd_type cmd_o;
  src_type       act_src;
  logic          fk, ask_on, ask_off, warn, sp_ok, wrong;
  logic [15:0]   err_code;
  int            fail_count = 0;
  int            n_checks   = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  key_pad_model u_key_pad_model (.clk_sys_i(clk_sys_i),
    .key_req_i(key_req), .keys_o(keys_i));
  drive_command_arbiter u_drive_command_arbiter (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .sel_src_i(sel_src_i), .map_i(map_i),
    .setpoint_switch_req_i(sp_req), .fn_i(fn_i), .keys_i(keys_i),
    .net_i(net_i), .cmd_o(cmd_o), .active_src_o(act_src),
    .full_keypad_o(fk), .ask_on_o(ask_on), .ask_off_o(ask_off),
    .show_warning_o(warn), .setpoint_switch_ok_o(sp_ok),
    .wrong_assign_o(wrong), .error_code_o(err_code));
  task automatic finish_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic go();
    @(posedge clk_sys_i);
  endtask : go
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic press(input keys_type k);
    go();
    key_req <= k;
    go();
    key_req <= '0;
  endtask : press
  task automatic wait_fk(input logic exp);
    int i;
    for (i = 0; i < 8 && fk !== exp; i++) tick(1);
    if (fk !== exp) begin
      fail_count++;
      finish_test();
    end
  endtask : wait_fk
  task automatic t_level();
    go();
    map_i <= '{1'b1, 1'b1, 1'b0, 1'b0};
    fn_i  <= 13'h1800;
    tick(2);
    chk(cmd_o.run, 1'b1);
    chk(cmd_o.reverse, 1'b0);
    chk(wrong, 1'b0);
    go();
    fn_i.drive_enable_fn <= 1'b0;
    tick(1);
    chk(cmd_o.output_enable, 1'b0);
    chk(cmd_o.run, 1'b0);
    go();
    fn_i <= 13'h1000;
    tick(2);
    chk(cmd_o.run, 1'b0);
  endtask : t_level
  task automatic t_edge();
    go();
    map_i <= '{1'b1, 1'b1, 1'b1, 1'b0};
    fn_i  <= 13'h1100;
    tick(2);
    go();
    fn_i.run_fn <= 1'b1;
    tick(3);
    chk(cmd_o.run, 1'b0);
    go();
    fn_i.start_fwd_edge_fn <= 1'b0;
    tick(2);
    go();
    fn_i.start_fwd_edge_fn <= 1'b1;
    tick(2);
    chk(cmd_o.run, 1'b1);
    chk(cmd_o.reverse, 1'b0);
    go();
    fn_i <= 13'h1000;
    tick(2);
    chk(cmd_o.run, 1'b0);
    go();
    fn_i <= 13'h1880;
    tick(2);
    chk(cmd_o.run, 1'b1);
    chk(cmd_o.reverse, 1'b1);
  endtask : t_edge
  task automatic t_levels();
    go();
    map_i <= '{1'b1, 1'b1, 1'b0, 1'b1};
    fn_i  <= 13'h1820;
    tick(2);
    chk(cmd_o.run, 1'b1);
    chk(cmd_o.reverse, 1'b1);
    go();
    fn_i.run_rev_level_fn <= 1'b0;
    tick(2);
    chk(cmd_o.run, 1'b0);
    go();
    map_i <= '{1'b1, 1'b1, 1'b1, 1'b1};
    tick(2);
    chk(err_code, 16'h6280);
    go();
    map_i <= '0;
    tick(2);
    chk(wrong, 1'b1);
    go();
    sel_src_i <= SRC_KEYPAD;
    tick(2);
    chk(wrong, 1'b0);
  endtask : t_levels
  task automatic t_jog();
    go();
    sel_src_i <= SRC_NETWORK;
    map_i     <= '{1'b1, 1'b1, 1'b0, 1'b1};
    fn_i      <= 13'h1820;
    net_i     <= '{1'b1, 1'b0};
    tick(2);
    chk(cmd_o.run, 1'b1);
    chk(cmd_o.reverse, 1'b0);
    go();
    fn_i <= 13'h1808;
    tick(2);
    chk(cmd_o.jog, 1'b1);
    chk(cmd_o.reverse, 1'b1);
    go();
    fn_i.quick_stop_fn <= 1'b1;
    tick(2);
    chk(cmd_o.jog, 1'b0);
    chk(cmd_o.run, 1'b0);
    chk(cmd_o.quick_stop, 1'b1);
    go();
    fn_i <= 13'h1804;
    tick(2);
    chk(cmd_o.setpoint_negate, 1'b0);
    go();
    sel_src_i <= SRC_FLEX;
    net_i     <= '0;
    tick(2);
    chk(cmd_o.setpoint_negate, 1'b1);
  endtask : t_jog
  task automatic t_keypad();
    go();
    map_i <= '{1'b1, 1'b1, 1'b0, 1'b0};
    fn_i  <= 13'h1800;
    press('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
    tick(2);
    chk(ask_on, 1'b1);
    press('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0});
    tick(3);
    chk(ask_on, 1'b0);
    chk(fk, 1'b0);
    press('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
    press('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
    tick(1);
    chk(cmd_o.changeover_stop, 1'b1);
    chk(cmd_o.run, 1'b0);
    wait_fk(1'b1);
    chk(cmd_o.run, 1'b0);
    chk(act_src, SRC_KEYPAD);
    go();
    sp_req <= 1'b1;
    fn_i   <= 13'h1203;
    tick(2);
    chk(sp_ok, 1'b0);
    chk(cmd_o.use_keypad_setpoint, 1'b1);
    chk(cmd_o.dc_brake, 1'b1);
    chk(cmd_o.ext_fault_one, 1'b1);
    chk(cmd_o.ext_fault_two, 1'b1);
    chk(warn, 1'b0);
    press('{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0});
    tick(4);
    chk(cmd_o.run, 1'b1);
    press('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0});
    tick(2);
    chk(ask_off, 1'b1);
    press('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
    tick(1);
    chk(cmd_o.changeover_stop, 1'b1);
    wait_fk(1'b0);
    chk(act_src, SRC_FLEX);
    chk(cmd_o.run, 1'b0);
  endtask : t_keypad
  initial begin
    repeat (6) @(posedge clk_sys_i);
    #1;
    chk(cmd_o, 11'h000);
    chk(err_code, 16'h0000);
    go();
    sys_rst_i <= 1'b0;
    t_level();
    t_edge();
    t_levels();
    t_jog();
    t_keypad();
    finish_test();
  end
endmodule : tb_drive_command_arbiter
